// File: hw/kpil_detect.v
// Falling-edge detector on the combined level of the enabled keypad pins
`timescale 1ns/1ps
module kpil_detect #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input  wire             clk_in,
    input  wire             resetn_in,
    // Pins and enables
    input  wire [WIDTH-1:0] pins_in,
    input  wire [WIDTH-1:0] enable_in,
    // Results
    output wire             any_low_out,
    output wire             fall_out
);
    reg  all_high_prev_reg;
    wire all_high;

    // ****************************************************************
    // Only enabled pins take part in the combined level
    // ****************************************************************
    assign all_high    = &(pins_in | ~enable_in);
    assign any_low_out = ~all_high;

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            all_high_prev_reg <= 1'b1;
        end else begin
            all_high_prev_reg <= all_high;
        end
    end

    // Fall only when all enabled pins were high before
    assign fall_out = all_high_prev_reg & ~all_high;
endmodule // kpil_detect

// File: hw/kpil_sync.v
// Two-stage synchroniser for a group of keypad pins
`timescale 1ns/1ps
module kpil_sync #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input  wire             clk_in,
    input  wire             resetn_in,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    // ****************************************************************
    // Idle level of a pulled-up pin is high
    // ****************************************************************
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stage1_reg <= {WIDTH{1'b1}};
            stage2_reg <= {WIDTH{1'b1}};
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule // kpil_sync

// File: hw/kpil_top.v
// Keypad interrupt latch: registers, request latch, mask and pull-ups
`timescale 1ns/1ps
`include "kpil_defs.vh"

// How it works
// - Four keypad inputs feed one request
// - Enabled pin turns on its pull-up
// - Each enable bit selects its pin
// - Latch when enabled pins fall from high
// - Edge mode ignores fall while another low
// - Level mode holds request while pin low
// - Level mode clears after ack and release
// - Vector fetch acknowledges the request
// - Acknowledge bit clears, reads zero
// - Fall after acknowledge latches again
// - Unmasked request uses vector FFE0/FFE1
// - Edge mode clears at once on ack
// - Reset clears latch, flag and mode
// - Pending flag shows latch despite mask
// - Mask bit blocks request to CPU
// - Mode bit selects edge or edge-level
// - Enable forces pin input, reads need direction
// - Reset clears the pin enable register
// - Detection active in wait and stop
// - Break blocks acknowledge bit write unless clear enabled; vector fetch still acknowledges
module kpil_top #(
    parameter PINS = `KPIL_PIN_COUNT
) (
    // Clock and reset
    input  wire                    REF_CLK_IN,
    input  wire                    RESETN_IN,
    // Register port
    input  wire [`KPIL_ADDR_W-1:0] ADDR_IN,
    input  wire [7:0]              WDATA_IN,
    input  wire                    WR_IN,
    input  wire                    RD_IN,
    output reg  [7:0]              RDATA_OUT,
    // Port A low pins
    input  wire [PINS-1:0]         PIN_LEVEL_IN,
    input  wire [PINS-1:0]         PIN_DIRECTION_IN,
    output reg  [PINS-1:0]         PULLUP_EN_OUT,
    output reg  [PINS-1:0]         FORCE_INPUT_OUT,
    // CPU interrupt side
    input  wire                    VECTOR_FETCH_IN,
    input  wire                    BREAK_STATE_IN,
    input  wire                    BREAK_CLEAR_ENABLE_IN,
    output reg                     IRQ_REQUEST_OUT,
    output reg                     WAKEUP_OUT,
    output reg  [15:0]             VECTOR_ADDR_OUT
);

    // ****************************************************************
    // State
    // ****************************************************************
    reg  [7:0]      pin_enable_reg;
    reg             trigger_mode_reg;
    reg             request_mask_reg;
    reg             latch_reg;
    reg             latch_next;
    reg             ack_seen_reg;
    reg             ack_seen_next;
    reg  [7:0]      rdata_next;
    wire [PINS-1:0] pins_sync;
    wire [PINS-1:0] pin_en;
    wire            any_low;
    wire            fall;
    wire            wr_sc;
    wire            sw_ack;
    wire            ack;

    assign pin_en = pin_enable_reg[PINS-1:0];

    // Write strobe aimed at one register offset
    function wr_hit;
        input                    wr;
        input [`KPIL_ADDR_W-1:0] addr;
        input [`KPIL_ADDR_W-1:0] offset;
        begin
            wr_hit = wr && (addr == offset);
        end
    endfunction

    // ****************************************************************
    // Pin synchroniser and edge detector
    // ****************************************************************
    kpil_sync #(
        .WIDTH     (PINS)
    ) u_sync (
        .clk_in    (REF_CLK_IN),
        .resetn_in (RESETN_IN),
        .async_in  (PIN_LEVEL_IN),
        .sync_out  (pins_sync)
    );

    kpil_detect #(
        .WIDTH       (PINS)
    ) u_detect (
        .clk_in      (REF_CLK_IN),
        .resetn_in   (RESETN_IN),
        .pins_in     (pins_sync),
        .enable_in   (pin_en),
        .any_low_out (any_low),
        .fall_out    (fall)
    );

    // ****************************************************************
    // Acknowledge sources
    // ****************************************************************
    assign wr_sc  = wr_hit(WR_IN, ADDR_IN, `KPIL_OFF_STATUS_CONTROL);
    assign sw_ack = wr_sc && WDATA_IN[`KPIL_BIT_ACKNOWLEDGE]
                    && (!BREAK_STATE_IN || BREAK_CLEAR_ENABLE_IN);
    assign ack    = sw_ack || VECTOR_FETCH_IN;

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pin_enable_reg   <= `KPIL_RST_PIN_ENABLE;
            trigger_mode_reg <= 1'b0;
            request_mask_reg <= 1'b0;
        end else begin
            if (wr_hit(WR_IN, ADDR_IN, `KPIL_OFF_PIN_ENABLE)) begin
                pin_enable_reg <= WDATA_IN;
            end
            if (wr_sc) begin
                trigger_mode_reg <= WDATA_IN[`KPIL_BIT_TRIGGER_MODE];
                request_mask_reg <= WDATA_IN[`KPIL_BIT_REQUEST_MASK];
            end
        end
    end

    // ****************************************************************
    // Request latch
    // ****************************************************************
    always @* begin
        latch_next    = latch_reg;
        ack_seen_next = ack_seen_reg;
        if (trigger_mode_reg) begin
            if (fall || any_low) begin
                latch_next = 1'b1;
            end
            if (ack) begin
                ack_seen_next = 1'b1;
            end
            if ((ack || ack_seen_reg) && !any_low && !fall) begin
                latch_next    = 1'b0;
                ack_seen_next = 1'b0;
            end
        end else begin
            ack_seen_next = 1'b0;
            if (ack) begin
                latch_next = 1'b0;
            end
            if (fall) begin
                latch_next = 1'b1;
            end
        end
        if (!latch_next) begin
            ack_seen_next = 1'b0;
        end
    end

    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            latch_reg    <= 1'b0;
            ack_seen_reg <= 1'b0;
        end else begin
            latch_reg    <= latch_next;
            ack_seen_reg <= ack_seen_next;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always @* begin
        rdata_next = 8'h00;
        case (ADDR_IN)
            `KPIL_OFF_STATUS_CONTROL: begin
                rdata_next[`KPIL_BIT_TRIGGER_MODE] = trigger_mode_reg;
                rdata_next[`KPIL_BIT_REQUEST_MASK] = request_mask_reg;
                rdata_next[`KPIL_BIT_PENDING_FLAG] = latch_reg;
            end
            `KPIL_OFF_PIN_ENABLE: begin
                rdata_next = pin_enable_reg;
            end
            `KPIL_OFF_PIN_LEVEL: begin
                rdata_next[PINS-1:0] = pins_sync & ~PIN_DIRECTION_IN;
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            RDATA_OUT       <= 8'h00;
            PULLUP_EN_OUT   <= {PINS{1'b0}};
            FORCE_INPUT_OUT <= {PINS{1'b0}};
            IRQ_REQUEST_OUT <= 1'b0;
            WAKEUP_OUT      <= 1'b0;
            VECTOR_ADDR_OUT <= `KPIL_VECTOR_HIGH;
        end else begin
            RDATA_OUT       <= RD_IN ? rdata_next : 8'h00;
            PULLUP_EN_OUT   <= pin_en;
            FORCE_INPUT_OUT <= pin_en;
            IRQ_REQUEST_OUT <= latch_next && !request_mask_reg;
            WAKEUP_OUT      <= latch_next && !request_mask_reg;
            VECTOR_ADDR_OUT <= `KPIL_VECTOR_HIGH;
        end
    end
endmodule // kpil_top

// File: include/kpil_defs.vh
// Register offsets, field positions, reset values and vectors of the keypad unit
`ifndef KPIL_DEFS_VH
`define KPIL_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define KPIL_ADDR_W              4
`define KPIL_OFF_STATUS_CONTROL  4'h0
`define KPIL_OFF_PIN_ENABLE      4'h1
`define KPIL_OFF_PIN_LEVEL       4'h2

// ****************************************************************
// Status and control fields
// ****************************************************************
`define KPIL_BIT_TRIGGER_MODE    0
`define KPIL_BIT_REQUEST_MASK    1
`define KPIL_BIT_ACKNOWLEDGE     2
`define KPIL_BIT_PENDING_FLAG    3

// ****************************************************************
// Reset values and vectors
// ****************************************************************
`define KPIL_RST_STATUS_CONTROL  8'h00
`define KPIL_RST_PIN_ENABLE      8'h00
`define KPIL_VECTOR_HIGH         16'hFFE0
`define KPIL_VECTOR_LOW          16'hFFE1
`define KPIL_PIN_COUNT           4

`endif

// File: verification/kpil_keypad_model.sv
// Keypad switches and CPU vector fetch model
`timescale 1ns/1ps
module kpil_keypad_model (
    // Clock
    input  wire       clk_in,
    // Keys and pull-ups
    input  wire [3:0] press_in,
    input  wire [3:0] pullup_in,
    output wire [3:0] pins_out,
    // CPU side
    input  wire       take_in,
    input  wire       irq_in,
    output reg        fetch_out
);
    reg [3:0] float_reg = 4'h5;
    initial fetch_out = 1'b0;
    // Unpulled open pin wanders
    always @(posedge clk_in) float_reg <= ~float_reg;
    assign pins_out = ~press_in & (pullup_in | float_reg);
    // CPU takes the vector of an unmasked request
    always @(posedge clk_in) fetch_out <= take_in & irq_in & ~fetch_out;
endmodule // kpil_keypad_model

// File: verification/kpil_top_chk.sv
// Port assertions for the keypad interrupt latch
`timescale 1ns/1ps
module kpil_top_chk #(
    parameter PINS = 4
) (
    input wire            REF_CLK_IN,
    input wire            RESETN_IN,
    input wire [3:0]      ADDR_IN,
    input wire [7:0]      WDATA_IN,
    input wire            WR_IN,
    input wire            RD_IN,
    input wire [7:0]      RDATA_OUT,
    input wire [PINS-1:0] PIN_LEVEL_IN,
    input wire [PINS-1:0] PULLUP_EN_OUT,
    input wire            VECTOR_FETCH_IN,
    input wire            BREAK_STATE_IN,
    input wire            BREAK_CLEAR_ENABLE_IN,
    input wire            IRQ_REQUEST_OUT
);
    // ****************************************************************
    // Shadow of mode, mask and enables
    // ****************************************************************
    reg            mode_reg;
    reg            mask_reg;
    reg [PINS-1:0] en_reg;
    wire           st_wr = WR_IN && ADDR_IN == 4'h0;
    wire           hi = &PIN_LEVEL_IN;
    wire           lo = (PIN_LEVEL_IN & en_reg) != en_reg;
    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            mode_reg <= 1'b0;
            mask_reg <= 1'b0;
            en_reg   <= {PINS{1'b0}};
        end else if (st_wr) begin
            mode_reg <= WDATA_IN[0];
            mask_reg <= WDATA_IN[1];
        end else if (WR_IN && ADDR_IN == 4'h1) begin
            en_reg   <= WDATA_IN[PINS-1:0];
        end
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    property p_pull;
        WR_IN && ADDR_IN == 4'h1 |=> ##1
            PULLUP_EN_OUT == $past(WDATA_IN[PINS-1:0], 2);
    endproperty
    a_pull: assert property (p_pull) else $error("pull-up mismatch");
    property p_ack0;
        RD_IN && ADDR_IN == 4'h0 |=> !RDATA_OUT[2];
    endproperty
    a_ack0: assert property (p_ack0) else $error("ack bit read high");
    property p_pend;
        RD_IN && ADDR_IN == 4'h0 && IRQ_REQUEST_OUT |=> RDATA_OUT[3];
    endproperty
    a_pend: assert property (p_pend) else $error("flag not shown");
    property p_fetch;
        hi[*3] ##0 (VECTOR_FETCH_IN && !mode_reg) |=> !IRQ_REQUEST_OUT;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch kept request");
    property p_swack;
        hi[*3] ##0 (st_wr && WDATA_IN[2] && !WDATA_IN[0] && !BREAK_STATE_IN)
            |=> !IRQ_REQUEST_OUT;
    endproperty
    a_swack: assert property (p_swack) else $error("ack kept request");
    property p_mask;
        mask_reg && $past(mask_reg) |-> !IRQ_REQUEST_OUT;
    endproperty
    a_mask: assert property (p_mask) else $error("masked request seen");
    property p_lvl;
        (mode_reg && !mask_reg && lo && $stable(en_reg) && IRQ_REQUEST_OUT)[*3]
            |=> IRQ_REQUEST_OUT;
    endproperty
    a_lvl: assert property (p_lvl) else $error("level request lost");
    property p_brk;
        st_wr && WDATA_IN[2] && !WDATA_IN[1] && BREAK_STATE_IN
            && !BREAK_CLEAR_ENABLE_IN && !VECTOR_FETCH_IN && IRQ_REQUEST_OUT
            && !mask_reg && !mode_reg
            |=> IRQ_REQUEST_OUT;
    endproperty
    a_brk: assert property (p_brk) else $error("break ack cleared");
endmodule // kpil_top_chk

bind kpil_top kpil_top_chk #(.PINS(PINS)) u_kpil_top_chk (.REF_CLK_IN,
    .RESETN_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT,
    .PIN_LEVEL_IN, .PULLUP_EN_OUT, .VECTOR_FETCH_IN, .BREAK_STATE_IN,
    .BREAK_CLEAR_ENABLE_IN, .IRQ_REQUEST_OUT);

// File: verification/test_keypad_interrupt_latch.sv
// Register-level testbench of the keypad interrupt latch
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module test_keypad_interrupt_latch;
    reg        clk = 0, rstn = 0, wr = 0, rd = 0, brk = 0, bce = 0, take = 0;
    reg  [3:0] addr = 0, press = 0, dir = 0;
    reg  [7:0] wd = 0, q;
    wire [7:0] rdata;
    wire [3:0] pins, pull, frc;
    wire       vf, irq, wake;
    wire [15:0] vec;
    int        err_count = 0, tests_run = 0;
    always #5 clk = ~clk;
    kpil_top u_kpil_top (.REF_CLK_IN(clk), .RESETN_IN(rstn), .ADDR_IN(addr),
        .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .PIN_LEVEL_IN(pins), .PIN_DIRECTION_IN(dir), .PULLUP_EN_OUT(pull),
        .FORCE_INPUT_OUT(frc), .VECTOR_FETCH_IN(vf), .BREAK_STATE_IN(brk),
        .BREAK_CLEAR_ENABLE_IN(bce), .IRQ_REQUEST_OUT(irq),
        .WAKEUP_OUT(wake), .VECTOR_ADDR_OUT(vec));
    kpil_keypad_model u_kpil_keypad_model (.clk_in(clk), .press_in(press),
        .pullup_in(pull), .pins_out(pins), .take_in(take), .irq_in(irq),
        .fetch_out(vf));
    // ****************************************************************
    // Bus and key tasks
    // ****************************************************************
    task wr8(input [3:0] a, input [7:0] d);
        @(posedge clk) begin addr <= a; wd <= d; wr <= 1; end
        @(posedge clk) wr <= 0;
        #1;
    endtask
    task rd8(input [3:0] a);
        @(posedge clk) begin addr <= a; rd <= 1; end
        @(posedge clk) rd <= 0;
        #1 q = rdata;
    endtask
    task key(input [3:0] p);
        @(posedge clk) press <= p;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task test_done;
        $display("Tests %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000 err_count++;
        test_done;
    end
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1;
        rd8(0); `CHK(q, 8'h00)
        rd8(1); `CHK(q, 8'h00)
        rd8(3); `CHK(q, 8'h00)
        wr8(0, 8'h02); wr8(1, 8'h0F); wr8(0, 8'h06); wr8(0, 8'h00);
        `CHK(pull, 4'hF)
        `CHK(frc, 4'hF)
        key(1); `CHK(irq, 1'b1)
        `CHK(wake, 1'b1)
        `CHK(vec, 16'hFFE0)
        rd8(0); `CHK(q, 8'h08)
        wr8(0, 8'h04); rd8(0); `CHK(q, 8'h00)
        key(3); `CHK(irq, 1'b0)
        key(0); key(4); `CHK(irq, 1'b1)
        key(0);
        @(posedge clk) take <= 1;
        repeat (4) @(posedge clk) take <= 0;
        #1 `CHK(irq, 1'b0)
        wr8(0, 8'h02); key(2); `CHK(irq, 1'b0)
        rd8(0); `CHK(q, 8'h0A)
        key(0); wr8(0, 8'h06); wr8(0, 8'h01);
        key(8); `CHK(irq, 1'b1)
        repeat (20) @(posedge clk);
        wr8(0, 8'h05); `CHK(irq, 1'b1)
        key(0); `CHK(irq, 1'b0)
        wr8(0, 8'h00); key(1);
        @(posedge clk) brk <= 1;
        wr8(0, 8'h04); `CHK(irq, 1'b1)
        @(posedge clk) bce <= 1;
        wr8(0, 8'h04); `CHK(irq, 1'b0)
        @(posedge clk) begin brk <= 0; bce <= 0; dir <= 4'h2; end
        rd8(2); `CHK(q, 8'h0C)
        key(0); wr8(1, 8'h01);
        @(posedge clk) #1 `CHK(pull, 4'h1)
        key(2); `CHK(irq, 1'b0)
        wr8(0, 8'h01); key(1); `CHK(irq, 1'b1)
        @(posedge clk) rstn <= 0;
        @(posedge clk) #1 `CHK(irq, 1'b0)
        @(posedge clk) rstn <= 1;
        rd8(0); `CHK(q, 8'h00)
        `CHK(pull, 4'h0)
        test_done;
    end
endmodule // test_keypad_interrupt_latch
